// [logic/l1_fsm_pkg.sv]
/*
 * Package for the access link layer-1 interface state machine: states,
 * error indication codes, timer presets and the event and report carriers.
 * Assumes a single 125 MHz clock feeding every user of the package.
 */
package l1_fsm_pkg;

	// Clock rate and the 100 ms timer quantum
	localparam int CLK_HZ          = 125000000;
	localparam int TICK_MS         = 100;
	localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
	// Presets are counts of 100 ms steps, 1 to 250 (100 ms to 25 s)
	localparam int STEP_MIN        = 1;
	localparam int STEP_MAX        = 250;
	localparam int STEP_W          = 8;
	// Default presets; operational shorter than non-operational on this side
	localparam logic [7:0] PRESET_OPER_DEF = 8'h0a;
	localparam logic [7:0] PRESET_FAIL_DEF = 8'h1e;

	typedef enum logic [3:0] {
		ST_NORMAL = 4'h1,
		ST_LOCAL  = 4'h2,
		ST_REMOTE = 4'h4,
		ST_INTERN = 4'h8
	} l1_state_t;

	// Error indication codes delivered to management
	typedef enum logic [3:0] {
		EI_NONE = 4'h0,
		EI_A    = 4'h1,
		EI_B    = 4'h2,
		EI_C    = 4'h3,
		EI_D    = 4'h4,
		EI_E    = 4'h5,
		EI_F    = 4'h6,
		EI_BR   = 4'h7,
		EI_DR   = 4'h8
	} ei_code_t;

	typedef enum logic [2:0] {
		TX_NORMAL = 3'h1,
		TX_RAI    = 3'h2,
		TX_AIS    = 3'h4
	} tx_mode_t;

	// One-cycle line event pulses from the framer
	typedef struct packed {
		logic normalFrames;
		logic lossSignal;
		logic lossFrame;
		logic rai;
		logic ais;
		logic intFail;
		logic intFailGone;
		logic crcErr;
		logic rxEbitZero;
	} line_events_t;

	// Primitives toward management
	typedef struct packed {
		logic     activate;
		logic     deactivate;
		logic     eiValid;
		ei_code_t eiCode;
		logic     eiRecovery;
	} mgmt_report_t;

endpackage

// [logic/persist_timer.sv]
/*
 * Persistence check timer counting whole 100 ms ticks.
 * Assumes tick is a one-cycle pulse every 100 ms from the parent divider.
 */
`timescale 1ns/10ps
`default_nettype none

module persist_timer #(
	parameter int STEP_W = 8
) (
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	input  wire logic              tick,
	input  wire logic              start,
	input  wire logic              stop,
	input  wire logic [STEP_W-1:0] preset,
	output logic                   expired,
	output logic                   running
);

	logic [STEP_W-1:0] count_reg;

	// Count steps; a restart reloads, so an earlier run can never expire
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			count_reg <= '0;
			running   <= 1'b0;
			expired   <= 1'b0;
		end
		else
		begin
			expired <= 1'b0;
			if (start)
			begin
				count_reg <= preset;
				running   <= 1'b1;
			end
			else if (stop)
				running <= 1'b0;
			else if (running && tick)
			begin
				if (count_reg <= STEP_W'(1))
				begin
					running <= 1'b0;
					expired <= 1'b1;
				end
				else
					count_reg <= count_reg - STEP_W'(1);
			end
		end
	end

endmodule

`default_nettype wire

// [logic/access_l1_fsm.sv]
/*
 * Layer-1 interface state machine for a 2048 kbit/s access link end.
 * Classifies line events, runs the persistence check, reports primitives.
 * Assumes event inputs are synchronous one-cycle pulses from the framer
 * and that management takes one report per cycle without back-pressure.
 */
// Behaviour
// - Timer presets are whole 100 ms steps from 100 ms to 25 s.
// - Timing error stays within 50 ms up to 1 s and within 10 % above 1 s.
// - Send normal frames in normal and remote failure, RAI in local, AIS in internal.
// - Signal loss, frame loss or AIS reports and moves to local failure per state.
// - Internal failure reports and enters internal state; its end goes to remote failure.
// - Timer expiry reports operational in normal, non-operational in failures, nothing in internal.
// - Presets may differ per event type and are fixed at build time.
// - Operational presets are shorter and non-operational longer on the access side.
// - Every detected event is reported at once with an error indication; normal frames and state-masked events give none here, at most one per cycle.
// - In normal and remote failure, CRC errors clear the outgoing E bit and report.
// - Received zero E bits are reported in normal state.
// - Persistent block error ratio worse than 1e-3 is a non-operational condition; here it only sets errRatioBad, with no state change or report.
// - After stop, the machine runs on but error indications are withheld.
// - After proceed, the last indication is re-sent and later ones flow again.
`timescale 1ns/10ps
`default_nettype none

module access_l1_fsm #(
	// fixed presets, operational shorter than non-operational
	parameter logic [7:0] PRESET_OPER  = l1_fsm_pkg::PRESET_OPER_DEF,
	parameter logic [7:0] PRESET_FAIL  = l1_fsm_pkg::PRESET_FAIL_DEF,
	parameter int         TICK_CYCLES  = l1_fsm_pkg::TICK_CYCLES,
	parameter int         BLOCK_WINDOW = 1000
) (
	input  wire logic                     ref_clk,
	input  wire logic                     rstn,
	input  wire l1_fsm_pkg::line_events_t lineEv,
	input  wire logic                     rxBlock,
	input  wire logic                     mphStop,
	input  wire logic                     mphProceed,
	output l1_fsm_pkg::mgmt_report_t      report,
	output l1_fsm_pkg::tx_mode_t          txMode,
	output logic                          txEbit,
	output l1_fsm_pkg::l1_state_t         state,
	output logic                          errRatioBad
);

	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int BW = $clog2(BLOCK_WINDOW + 1);

	l1_fsm_pkg::l1_state_t state_next;
	logic [TW-1:0]         tickCnt_reg;
	logic                  tick;
	logic                  tmrStart;
	logic [7:0]            tmrPreset;
	logic                  tmrExpired;
	logic                  tmrRunning;
	logic                  stopped_reg;
	l1_fsm_pkg::ei_code_t  lastCode_reg;
	logic                  lastRec_reg;
	logic                  evLoss;
	logic                  crcActive;
	logic [BW-1:0]         blkCnt_reg;
	logic [BW-1:0]         errCnt_reg;
	logic [4:0]            pendEi_reg;

	// divider restarts with the timer, so no step is ever cut short
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			tickCnt_reg <= '0;
		else if (tmrStart || tickCnt_reg == TW'(TICK_CYCLES - 1))
			tickCnt_reg <= '0;
		else
			tickCnt_reg <= tickCnt_reg + TW'(1);
	end
	assign tick = (tickCnt_reg == TW'(TICK_CYCLES - 1));

	assign evLoss = lineEv.lossSignal | lineEv.lossFrame | lineEv.ais;

	// Next state per event; internal failure has the highest priority
	always_comb
	begin
		state_next = state;
		tmrStart   = 1'b0;
		tmrPreset  = PRESET_FAIL;
		unique case (state)
			l1_fsm_pkg::ST_NORMAL:
			begin
				if (lineEv.intFail)
					state_next = l1_fsm_pkg::ST_INTERN;
				else if (evLoss)
				begin
					state_next = l1_fsm_pkg::ST_LOCAL;
					tmrStart   = 1'b1;
				end
				else if (lineEv.rai)
				begin
					state_next = l1_fsm_pkg::ST_REMOTE;
					tmrStart   = 1'b1;
				end
			end
			l1_fsm_pkg::ST_LOCAL:
			begin
				if (lineEv.intFail)
					state_next = l1_fsm_pkg::ST_INTERN;
				else if (lineEv.rai)
					state_next = l1_fsm_pkg::ST_REMOTE;
				else if (lineEv.normalFrames)
				begin
					state_next = l1_fsm_pkg::ST_NORMAL;
					tmrStart   = 1'b1;
					tmrPreset  = PRESET_OPER;
				end
			end
			l1_fsm_pkg::ST_REMOTE:
			begin
				if (lineEv.intFail)
					state_next = l1_fsm_pkg::ST_INTERN;
				else if (evLoss)
				begin
					state_next = l1_fsm_pkg::ST_LOCAL;
					tmrStart   = 1'b1;
				end
				else if (lineEv.normalFrames)
				begin
					state_next = l1_fsm_pkg::ST_NORMAL;
					tmrStart   = 1'b1;
					tmrPreset  = PRESET_OPER;
				end
			end
			l1_fsm_pkg::ST_INTERN:
			begin
				if (lineEv.intFailGone)
					state_next = l1_fsm_pkg::ST_REMOTE;
			end
			default:
				state_next = l1_fsm_pkg::ST_NORMAL;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			state <= l1_fsm_pkg::ST_NORMAL;
		else
			state <= state_next;
	end

	// contrary event restarts; internal failure stops the check
	persist_timer #(
		.STEP_W (l1_fsm_pkg::STEP_W)
	) persist_timer_inst (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.tick    (tick),
		.start   (tmrStart),
		.stop    (state_next == l1_fsm_pkg::ST_INTERN),
		.preset  (tmrPreset),
		.expired (tmrExpired),
		.running (tmrRunning)
	);

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			txMode <= l1_fsm_pkg::TX_NORMAL;
		else if (state_next == l1_fsm_pkg::ST_LOCAL)
			txMode <= l1_fsm_pkg::TX_RAI;
		else if (state_next == l1_fsm_pkg::ST_INTERN)
			txMode <= l1_fsm_pkg::TX_AIS;
		else
			txMode <= l1_fsm_pkg::TX_NORMAL;
	end

	assign crcActive = (state == l1_fsm_pkg::ST_NORMAL) || (state == l1_fsm_pkg::ST_REMOTE);

	// outgoing E bit zero for an errored block
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			txEbit <= 1'b1;
		else
			txEbit <= !(crcActive && lineEv.crcErr);
	end

	// errored blocks per window; more than one per thousand is bad
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			blkCnt_reg  <= '0;
			errCnt_reg  <= '0;
			errRatioBad <= 1'b0;
		end
		else if (rxBlock)
		begin
			if (blkCnt_reg == BW'(BLOCK_WINDOW - 1))
			begin
				blkCnt_reg  <= '0;
				errCnt_reg  <= '0;
				errRatioBad <= (errCnt_reg + BW'(crcActive && lineEv.crcErr)) > BW'(1);
			end
			else
			begin
				blkCnt_reg <= blkCnt_reg + BW'(1);
				if (crcActive && lineEv.crcErr)
					errCnt_reg <= errCnt_reg + BW'(1);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			stopped_reg <= 1'b0;
		else if (mphProceed)
			stopped_reg <= 1'b0;
		else if (mphStop)
			stopped_reg <= 1'b1;
	end

	// indication per cycle, highest priority first; a held pair half comes last
	function automatic logic [4:0] pick_ei(input l1_fsm_pkg::l1_state_t st,
		input l1_fsm_pkg::line_events_t ev, input logic [4:0] pend);
		logic [4:0] r;
		r = pend;
		if (ev.intFail && st != l1_fsm_pkg::ST_INTERN)
			r = {1'b0, l1_fsm_pkg::EI_D};
		else if (ev.intFailGone && st == l1_fsm_pkg::ST_INTERN)
			r = {1'b1, l1_fsm_pkg::EI_D};
		else if (ev.lossSignal || ev.lossFrame)
			r = {1'b0, l1_fsm_pkg::EI_A};
		else if (ev.ais)
			r = {1'b0, l1_fsm_pkg::EI_C};
		else if (ev.rai && (st == l1_fsm_pkg::ST_NORMAL || st == l1_fsm_pkg::ST_LOCAL))
			r = (st == l1_fsm_pkg::ST_LOCAL) ? {1'b1, l1_fsm_pkg::EI_D}
				: {1'b0, l1_fsm_pkg::EI_B};
		else if (ev.crcErr && (st == l1_fsm_pkg::ST_NORMAL || st == l1_fsm_pkg::ST_REMOTE))
			r = {1'b0, l1_fsm_pkg::EI_E};
		else if (ev.rxEbitZero && st == l1_fsm_pkg::ST_NORMAL)
			r = {1'b0, l1_fsm_pkg::EI_F};
		return r;
	endfunction

	logic [4:0] pick;
	assign pick = pick_ei(state, lineEv, pendEi_reg);

	// immediate indication; replay last on proceed
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			report       <= '0;
			pendEi_reg   <= '0;
			lastCode_reg <= l1_fsm_pkg::EI_NONE;
			lastRec_reg  <= 1'b0;
		end
		else
		begin
			report.activate   <= tmrExpired && state == l1_fsm_pkg::ST_NORMAL;
			report.deactivate <= (tmrExpired && (state == l1_fsm_pkg::ST_LOCAL
				|| state == l1_fsm_pkg::ST_REMOTE))
				|| (lineEv.intFail && state != l1_fsm_pkg::ST_INTERN);
			report.eiValid    <= 1'b0;
			report.eiCode     <= l1_fsm_pkg::EI_NONE;
			report.eiRecovery <= 1'b0;
			// second half of a paired indication follows one cycle later
			pendEi_reg <= (state == l1_fsm_pkg::ST_LOCAL && lineEv.rai && !lineEv.intFail)
				? {1'b0, l1_fsm_pkg::EI_B}
				: (state == l1_fsm_pkg::ST_REMOTE && evLoss && !lineEv.intFail)
				? {1'b1, l1_fsm_pkg::EI_B} : {1'b0, l1_fsm_pkg::EI_NONE};
			if (pick[3:0] != l1_fsm_pkg::EI_NONE)
			begin
				lastCode_reg <= l1_fsm_pkg::ei_code_t'(pick[3:0]);
				lastRec_reg  <= pick[4];
			end
			if (pick[3:0] != l1_fsm_pkg::EI_NONE && (!stopped_reg || mphProceed))
			begin
				report.eiValid    <= 1'b1;
				report.eiCode     <= l1_fsm_pkg::ei_code_t'(pick[3:0]);
				report.eiRecovery <= pick[4];
			end
			else if (mphProceed && stopped_reg && lastCode_reg != l1_fsm_pkg::EI_NONE)
			begin
				report.eiValid    <= 1'b1;
				report.eiCode     <= lastCode_reg;
				report.eiRecovery <= lastRec_reg;
			end
		end
	end

	a_loss_to_local: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state == l1_fsm_pkg::ST_NORMAL && !lineEv.intFail && evLoss)
		|=> state == l1_fsm_pkg::ST_LOCAL && txMode == l1_fsm_pkg::TX_RAI)
		else $error("loss event did not enter local failure");
	a_rai_to_remote: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state == l1_fsm_pkg::ST_LOCAL && !lineEv.intFail && lineEv.rai)
		|=> state == l1_fsm_pkg::ST_REMOTE)
		else $error("RAI did not enter remote failure");
	a_intern_enter: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state != l1_fsm_pkg::ST_INTERN && lineEv.intFail)
		|=> state == l1_fsm_pkg::ST_INTERN && report.deactivate)
		else $error("internal failure not handled");
	a_tx_ais: assert property (@(posedge ref_clk) disable iff (!rstn)
		state == l1_fsm_pkg::ST_INTERN |-> txMode == l1_fsm_pkg::TX_AIS)
		else $error("AIS not sent in internal failure");
	a_expiry_oper: assert property (@(posedge ref_clk) disable iff (!rstn)
		(tmrExpired && state == l1_fsm_pkg::ST_NORMAL) |=> report.activate)
		else $error("expiry in normal did not activate");
	a_crc_ebit: assert property (@(posedge ref_clk) disable iff (!rstn)
		(crcActive && lineEv.crcErr) |=> !txEbit)
		else $error("E bit not cleared on CRC error");
	a_stop_silent: assert property (@(posedge ref_clk) disable iff (!rstn)
		(stopped_reg && !mphProceed) |=> !report.eiValid)
		else $error("indication sent while stopped");
	a_ebit_report: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state == l1_fsm_pkg::ST_NORMAL && lineEv.rxEbitZero && !stopped_reg
		&& pick[3:0] == l1_fsm_pkg::EI_F) |=> report.eiValid
		&& report.eiCode == l1_fsm_pkg::EI_F)
		else $error("received E bit zero not reported");
	a_proceed_replay: assert property (@(posedge ref_clk) disable iff (!rstn)
		(mphProceed && stopped_reg && lastCode_reg != l1_fsm_pkg::EI_NONE)
		|=> report.eiValid)
		else $error("proceed did not replay indication");
	a_recover_start: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state == l1_fsm_pkg::ST_REMOTE && lineEv.normalFrames && !evLoss && !lineEv.intFail)
		|=> state == l1_fsm_pkg::ST_NORMAL && tmrRunning)
		else $error("recovery did not start timer");

	c_local: cover property (@(posedge ref_clk) state == l1_fsm_pkg::ST_LOCAL);
	c_activate: cover property (@(posedge ref_clk) report.activate);
	c_replay: cover property (@(posedge ref_clk) mphProceed && stopped_reg);
	c_bad_ratio: cover property (@(posedge ref_clk) errRatioBad);

endmodule

`default_nettype wire

// [testbench/remote_line_model.sv]
/*
 * Remote line termination model: sends one-cycle framer event pulses and CRC block strobes.
 * Assumes the bench calls its tasks from one process only.
 */
`timescale 1ns/10ps
`default_nettype none

module remote_line_model (
	input  wire logic                ref_clk,
	input  wire logic                rstn,
	output l1_fsm_pkg::line_events_t lineEv,
	output logic                     rxBlock
);
	initial
	begin
		lineEv = '0;
		rxBlock = 1'b0;
	end

	// Falling-edge changes reach the rising edge settled; nothing is sent in reset
	task automatic pulse(input logic [8:0] ev, input logic blk);
		@(negedge ref_clk);
		lineEv = rstn ? ev : 9'h000;
		rxBlock = rstn & blk;
		@(negedge ref_clk);
		lineEv = '0;
		rxBlock = 1'b0;
	endtask

	task automatic blockRun(input int n, input int nErr);
		for (int i = 0; i < n; i++)
			pulse((i < nErr) ? 9'h002 : 9'h000, 1'b1);
	endtask
endmodule

`default_nettype wire

// [testbench/access_l1_fsm_tb_top.sv]
/*
 * Self-checking bench for the layer-1 interface state machine.
 * Assumes a short tick and short presets so each timer runs in tens of cycles.
 */
`timescale 1ns/10ps
`default_nettype none

module access_l1_fsm_tb_top;
	localparam int         TCK  = 10;
	localparam int         OPER = 2;
	localparam int         FAIL = 4;
	localparam int         WIN  = 8;
	localparam logic [8:0] EV_NF  = 9'h100;
	localparam logic [8:0] EV_LOS = 9'h080;
	localparam logic [8:0] EV_LOF = 9'h040;
	localparam logic [8:0] EV_RAI = 9'h020;
	localparam logic [8:0] EV_AIS = 9'h010;
	localparam logic [8:0] EV_IF  = 9'h008;
	localparam logic [8:0] EV_IFG = 9'h004;
	localparam logic [8:0] EV_CRC = 9'h002;
	localparam logic [8:0] EV_EBZ = 9'h001;

	logic                      ref_clk = 1'b0;
	logic                      rstn = 1'b0;
	logic                      mphStop = 1'b0;
	logic                      mphProceed = 1'b0;
	l1_fsm_pkg::line_events_t  lineEv;
	logic                      rxBlock;
	l1_fsm_pkg::mgmt_report_t  report;
	l1_fsm_pkg::tx_mode_t      txMode;
	logic                      txEbit;
	l1_fsm_pkg::l1_state_t     state;
	logic                      errRatioBad;
	int                        errors = 0;
	int                        n_compared = 0;
	int                        cycles = 0;

	always #4 ref_clk = ~ref_clk;

	remote_line_model remote_line_model_inst (
		.ref_clk(ref_clk), .rstn(rstn), .lineEv(lineEv), .rxBlock(rxBlock)
	);

	access_l1_fsm #(
		.PRESET_OPER(8'h02), .PRESET_FAIL(8'h04), .TICK_CYCLES(TCK), .BLOCK_WINDOW(WIN)
	) access_l1_fsm_inst (
		.ref_clk(ref_clk), .rstn(rstn), .lineEv(lineEv), .rxBlock(rxBlock),
		.mphStop(mphStop), .mphProceed(mphProceed), .report(report), .txMode(txMode),
		.txEbit(txEbit), .state(state), .errRatioBad(errRatioBad)
	);

	task automatic end_of_test();
		if (errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// A stuck sequence would otherwise never reach the verdict
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			errors++;
			$display("FAIL at %0t: run did not complete", $time);
			end_of_test();
		end
	end

	task automatic chk(input bit ok, input string msg);
		n_compared++;
		if (!ok)
		begin
			errors++;
			$display("FAIL at %0t: %s", $time, msg);
		end
	endtask

	task automatic send(input logic [8:0] ev, input logic blk = 1'b0);
		remote_line_model_inst.pulse(ev, blk);
	endtask

	task automatic rep(input l1_fsm_pkg::ei_code_t code, input l1_fsm_pkg::l1_state_t st);
		chk(report.eiValid === 1'b1 && report.eiCode === code, "wrong error indication");
		chk(state === st, "wrong state");
	endtask

	task automatic quiet(input l1_fsm_pkg::l1_state_t st);
		chk(report.eiValid === 1'b0 && state === st, "event not ignored");
	endtask

	// Waits for one status pulse, flagging the contrary one as a stale report
	task automatic expectPulse(input bit act, input int lo, input int hi);
		int  n;
		bit  seen;
		n = 0;
		seen = 1'b0;
		while (!seen && n <= hi)
		begin
			@(negedge ref_clk);
			n++;
			if ((act ? report.deactivate : report.activate) === 1'b1)
				chk(1'b0, "contrary status report");
			seen = (act ? report.activate : report.deactivate) === 1'b1;
		end
		chk(seen && n >= lo, "status report timing");
	endtask

	task automatic noPulse(input int n);
		bit  bad;
		bad = 1'b0;
		repeat (n)
		begin
			@(negedge ref_clk);
			bad |= report.activate !== 1'b0 || report.deactivate !== 1'b0;
		end
		chk(!bad, "unexpected status report");
	endtask

	task automatic goNormal();
		send(EV_NF);
		chk(state === l1_fsm_pkg::ST_NORMAL && txMode === l1_fsm_pkg::TX_NORMAL, "no return");
		expectPulse(1'b1, OPER * TCK - TCK / 2, OPER * TCK + 3);
	endtask

	task automatic mgmt(input bit stop);
		@(negedge ref_clk);
		if (stop)
			mphStop = 1'b1;
		else
			mphProceed = 1'b1;
		@(negedge ref_clk);
		mphStop = 1'b0;
		mphProceed = 1'b0;
	endtask

	task automatic t_reset();
		chk(state === l1_fsm_pkg::ST_NORMAL && txMode === l1_fsm_pkg::TX_NORMAL
			&& txEbit === 1'b1 && report === '0 && errRatioBad === 1'b0, "reset values");
	endtask

	task automatic t_ratio();
		remote_line_model_inst.blockRun(WIN, 2);
		repeat (3) @(negedge ref_clk);
		chk(errRatioBad === 1'b1, "ratio not flagged");
		remote_line_model_inst.blockRun(WIN, 1);
		repeat (3) @(negedge ref_clk);
		chk(errRatioBad === 1'b0, "ratio flag stuck");
	endtask

	task automatic t_local();
		send(EV_LOF);
		rep(l1_fsm_pkg::EI_A, l1_fsm_pkg::ST_LOCAL);
		chk(txMode === l1_fsm_pkg::TX_RAI, "tx mode in local failure");
		expectPulse(1'b0, FAIL * TCK - TCK / 2, FAIL * TCK + 3);
		send(EV_LOS);
		rep(l1_fsm_pkg::EI_A, l1_fsm_pkg::ST_LOCAL);
		send(EV_CRC, 1'b1);
		chk(report.eiValid === 1'b0 && txEbit === 1'b1, "crc checked in local failure");
		goNormal();
	endtask

	task automatic t_remote();
		send(EV_RAI);
		rep(l1_fsm_pkg::EI_B, l1_fsm_pkg::ST_REMOTE);
		chk(txMode === l1_fsm_pkg::TX_NORMAL, "tx mode in remote failure");
		send(EV_RAI);
		quiet(l1_fsm_pkg::ST_REMOTE);
		send(EV_CRC, 1'b1);
		rep(l1_fsm_pkg::EI_E, l1_fsm_pkg::ST_REMOTE);
		chk(txEbit === 1'b0, "E bit not cleared");
		send(EV_AIS);
		rep(l1_fsm_pkg::EI_C, l1_fsm_pkg::ST_LOCAL);
		@(negedge ref_clk);
		rep(l1_fsm_pkg::EI_B, l1_fsm_pkg::ST_LOCAL);
		chk(report.eiRecovery === 1'b1, "remote failure end not reported");
		expectPulse(1'b0, FAIL * TCK - TCK / 2, FAIL * TCK + 3);
		send(EV_RAI);
		chk(state === l1_fsm_pkg::ST_REMOTE && report.eiCode === l1_fsm_pkg::EI_D
			&& report.eiRecovery === 1'b1, "local to remote");
		@(negedge ref_clk);
		rep(l1_fsm_pkg::EI_B, l1_fsm_pkg::ST_REMOTE);
		goNormal();
	endtask

	task automatic t_internal();
		send(EV_LOF);
		rep(l1_fsm_pkg::EI_A, l1_fsm_pkg::ST_LOCAL);
		send(EV_IF);
		rep(l1_fsm_pkg::EI_D, l1_fsm_pkg::ST_INTERN);
		chk(report.deactivate === 1'b1 && txMode === l1_fsm_pkg::TX_AIS, "internal entry");
		send(EV_LOS);
		rep(l1_fsm_pkg::EI_A, l1_fsm_pkg::ST_INTERN);
		send(EV_RAI);
		quiet(l1_fsm_pkg::ST_INTERN);
		noPulse((FAIL + 1) * TCK + 5);
		send(EV_IFG);
		rep(l1_fsm_pkg::EI_D, l1_fsm_pkg::ST_REMOTE);
		chk(report.eiRecovery === 1'b1, "recovery variant");
		goNormal();
	endtask

	task automatic t_stale();
		send(EV_LOF);
		rep(l1_fsm_pkg::EI_A, l1_fsm_pkg::ST_LOCAL);
		repeat (TCK) @(negedge ref_clk);
		goNormal();
		noPulse((FAIL + 1) * TCK);
	endtask

	task automatic t_crc();
		send(EV_CRC, 1'b1);
		rep(l1_fsm_pkg::EI_E, l1_fsm_pkg::ST_NORMAL);
		chk(txEbit === 1'b0, "E bit not cleared");
		@(negedge ref_clk);
		chk(txEbit === 1'b1, "E bit held too long");
		send(EV_EBZ);
		rep(l1_fsm_pkg::EI_F, l1_fsm_pkg::ST_NORMAL);
		send(EV_CRC | EV_EBZ, 1'b1);
		rep(l1_fsm_pkg::EI_E, l1_fsm_pkg::ST_NORMAL);
	endtask

	task automatic t_stop();
		mgmt(1'b1);
		send(EV_LOF);
		chk(state === l1_fsm_pkg::ST_LOCAL && report.eiValid === 1'b0, "not withheld");
		expectPulse(1'b0, FAIL * TCK - TCK / 2, FAIL * TCK + 3);
		mgmt(1'b0);
		rep(l1_fsm_pkg::EI_A, l1_fsm_pkg::ST_LOCAL);
		send(EV_IF);
		rep(l1_fsm_pkg::EI_D, l1_fsm_pkg::ST_INTERN);
		send(EV_IFG);
		goNormal();
	endtask

	initial
	begin
		repeat (5) @(negedge ref_clk);
		rstn = 1'b1;
		t_reset();
		t_ratio();
		t_local();
		t_remote();
		t_internal();
		t_stale();
		t_crc();
		t_stop();
		end_of_test();
	end
endmodule

`default_nettype wire
